/* verilog/mctec_timer.sv */
// 16-bit match-clear timer/event counter top
`timescale 1ns/10ps
module mctec_timer
#(
    parameter int INSTANCE = 0
)
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic [1:0] run_mode_i,
    input wire logic [1:0] source_select_i,
    input wire logic [1:0] event_edge_sel_i,
    input wire logic [15:0] compare_zero_i,
    input wire logic [15:0] compare_one_i,
    input wire logic toggle_on_match_zero_i,
    input wire logic toggle_on_match_one_i,
    input wire logic output_enable_bit_i,
    input wire logic overflow_clear_i,
    input wire logic event_input_pin_i,
    output logic [15:0] counter_value_o,
    output logic match_zero_irq_o,
    output logic match_one_irq_o,
    output logic overflow_flag_o,
    output logic timer_output_pin_o
);
    import mctec_pkg::*;

    // refuse an instance number that has no divider table
    if (INSTANCE < 0 || INSTANCE > 3)
    begin : g_bad_instance
        $error("INSTANCE must be 0 to 3");
    end

    localparam bit HIGH_PAIR = (INSTANCE >= 2);
    localparam int DIV_B = HIGH_PAIR ? MCTEC_DIV_B_HIGH : MCTEC_DIV_B_LOW;
    localparam int DIV_C = HIGH_PAIR ? MCTEC_DIV_C_HIGH : MCTEC_DIV_C_LOW;

    ////////////////////////////////////////////////////////////////////////
    logic [MCTEC_PRESCALE_W-1:0] pre_reg;
    logic tick_next;
    logic ev_edge;
    logic running;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic wrap;
    logic hit0;
    logic hit1;
    logic step;
    mctec_state_t state_reg;

    assign running = (run_mode_i != MCTEC_RUN_STOP);

    mctec_event_filter u_filter
    (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .pin_i(event_input_pin_i),
        .edge_sel_i(event_edge_sel_i),
        .edge_o(ev_edge)
    );

    // free prescaler held at zero while stopped so starts line up
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !running)
        begin
            pre_reg <= '0;
        end
        else
        begin
            pre_reg <= pre_reg + 1'b1;
        end
    end

    function automatic logic div_hit(input logic [MCTEC_PRESCALE_W-1:0] p, input int div);
        div_hit = (p == MCTEC_PRESCALE_W'(div - 1));
    endfunction

    // count enable is a one-cycle pulse, never a derived clock
    always_comb
    begin
        tick_next = 1'b0;
        case (source_select_i)
            2'h0: tick_next = (pre_reg[1:0] == 2'h3);
            2'h1: tick_next = div_hit(pre_reg & MCTEC_PRESCALE_W'(DIV_B - 1), DIV_B);
            2'h2: tick_next = div_hit(pre_reg & MCTEC_PRESCALE_W'(DIV_C - 1), DIV_C);
            default: tick_next = ev_edge;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // start sequence: first count clock after start loads zero, so the first
    // match comes one count later than the steady period
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !running)
        begin
            state_reg <= MCTEC_ST_IDLE;
        end
        else
        begin
            case (state_reg)
                MCTEC_ST_IDLE: state_reg <= MCTEC_ST_ARM;
                MCTEC_ST_ARM: if (tick_next) state_reg <= MCTEC_ST_RUN;
                default: state_reg <= MCTEC_ST_RUN;
            endcase
        end
    end

    assign step = tick_next && (state_reg == MCTEC_ST_RUN);
    assign hit0 = step && (count_reg == compare_zero_i);
    assign hit1 = step && (count_reg == compare_one_i);
    assign wrap = step && (count_reg == MCTEC_COUNT_MAX);

    always_comb
    begin
        count_next = count_reg + 16'h0001;
        if (run_mode_i == MCTEC_RUN_MATCH && count_reg == compare_zero_i)
        begin
            count_next = MCTEC_COUNT_RESET;
        end
        else if (run_mode_i == MCTEC_RUN_EDGE && ev_edge)
        begin
            count_next = MCTEC_COUNT_RESET;
        end
    end

    // counter is read directly; no read side effect
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !running)
        begin
            count_reg <= MCTEC_COUNT_RESET;
        end
        else if (step)
        begin
            count_reg <= count_next;
        end
    end

    assign counter_value_o = count_reg;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            match_zero_irq_o <= 1'b0;
            match_one_irq_o <= 1'b0;
        end
        else
        begin
            match_zero_irq_o <= hit0;
            match_one_irq_o <= hit1;
        end
    end

    // set wins over software clear; stop also clears
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            overflow_flag_o <= 1'b0;
        end
        else if (wrap)
        begin
            overflow_flag_o <= 1'b1;
        end
        else if (overflow_clear_i || !running)
        begin
            overflow_flag_o <= 1'b0;
        end
    end

    logic tout_reg;
    always_ff @(posedge mclk_i)
    begin
        if (reset_i || !running)
        begin
            tout_reg <= 1'b0;
        end
        else if ((hit0 && toggle_on_match_zero_i) || (hit1 && toggle_on_match_one_i))
        begin
            tout_reg <= ~tout_reg;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            timer_output_pin_o <= 1'b0;
        end
        else
        begin
            timer_output_pin_o <= output_enable_bit_i &
                (((hit0 && toggle_on_match_zero_i) || (hit1 && toggle_on_match_one_i)) ^ tout_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_STOP_CLEARS: assert property (@(posedge mclk_i) disable iff (reset_i)
        run_mode_i == MCTEC_RUN_STOP |=> counter_value_o == 16'h0000)
        else $error("counter not cleared while stopped");
    AST_MATCH_CLEARS: assert property (@(posedge mclk_i) disable iff (reset_i)
        hit0 && run_mode_i == MCTEC_RUN_MATCH && $stable(run_mode_i) |=> counter_value_o == 16'h0000)
        else $error("match did not clear counter");
    AST_MATCH_IRQ: assert property (@(posedge mclk_i) disable iff (reset_i)
        step && running && count_reg == compare_zero_i |=> match_zero_irq_o)
        else $error("match zero irq missing");
    AST_ONE_IRQ: assert property (@(posedge mclk_i) disable iff (reset_i)
        match_one_irq_o |-> $past(count_reg) == $past(compare_one_i))
        else $error("spurious match one irq");
    AST_PIN_LOW: assert property (@(posedge mclk_i) disable iff (reset_i)
        !output_enable_bit_i |=> !timer_output_pin_o)
        else $error("output pin not low when disabled");
    AST_TOGGLE: assert property (@(posedge mclk_i) disable iff (reset_i)
        output_enable_bit_i && $stable(output_enable_bit_i) && running && $past(running) && match_zero_irq_o
        && toggle_on_match_zero_i && !toggle_on_match_one_i && !match_one_irq_o
        |-> timer_output_pin_o != $past(timer_output_pin_o))
        else $error("pin did not toggle on match");
    AST_OVF: assert property (@(posedge mclk_i) disable iff (reset_i)
        wrap |=> overflow_flag_o)
        else $error("overflow flag not set on wrap");
    AST_DIV4: assert property (@(posedge mclk_i) disable iff (reset_i)
        step && source_select_i == 2'h0 && $stable(source_select_i) && running ##1 running [*3]
        |-> !tick_next)
        else $error("divide by four ticks too often");
    AST_EVENT_ONLY: assert property (@(posedge mclk_i) disable iff (reset_i)
        source_select_i == MCTEC_SRC_EVENT && step |-> ev_edge)
        else $error("event count without edge");
    COV_MATCH: cover property (@(posedge mclk_i) disable iff (reset_i) hit0 && run_mode_i == MCTEC_RUN_MATCH);
    COV_EVENT: cover property (@(posedge mclk_i) disable iff (reset_i) hit0 && source_select_i == MCTEC_SRC_EVENT);
    COV_TOGGLE: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(timer_output_pin_o));
    COV_WRAP: cover property (@(posedge mclk_i) disable iff (reset_i) wrap);
endmodule

/* common/mctec_pkg.sv */
// package: constants and types for the match-clear timer/event counter
//
// Notes on behaviour
// - instances 0,1: source 00/01/10 = /4,/16,/32
// - instances 2,3: source 00/01/10 = /4,/1024,/2048
// - run mode 11 starts counting with count clock
// - match with compare zero clears, raises irq
// - match period is compare plus one counts
// - compare one match always raises its irq
// - counter read never disturbs counting
// - output control 03H toggles pin per match
// - square wave period is 2(M+1) counts
// - source 11 counts valid event edges
// - first event interrupt after compare plus two
// - event edge needs two equal samples
// - run mode 00 stops and clears counter
// - run modes: stop, free, edge-clear, match-clear
// - output enable low holds pin low
// - overflow flag sets on FFFF to 0000 wrap
package mctec_pkg;
    localparam logic [1:0] MCTEC_RUN_STOP = 2'h0;
    localparam logic [1:0] MCTEC_RUN_FREE = 2'h1;
    localparam logic [1:0] MCTEC_RUN_EDGE = 2'h2;
    localparam logic [1:0] MCTEC_RUN_MATCH = 2'h3;
    localparam logic [1:0] MCTEC_SRC_EVENT = 2'h3;
    localparam logic [15:0] MCTEC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] MCTEC_COUNT_MAX = 16'hFFFF;
    localparam int MCTEC_DIV_A = 4;
    localparam int MCTEC_DIV_B_LOW = 16;
    localparam int MCTEC_DIV_C_LOW = 32;
    localparam int MCTEC_DIV_B_HIGH = 1024;
    localparam int MCTEC_DIV_C_HIGH = 2048;
    localparam int MCTEC_PRESCALE_W = 11;
    // edge select encodings for the event pin
    localparam logic [1:0] MCTEC_EDGE_FALL = 2'h0;
    localparam logic [1:0] MCTEC_EDGE_RISE = 2'h1;
    localparam logic [1:0] MCTEC_EDGE_BOTH = 2'h3;
    typedef enum logic [1:0] {MCTEC_ST_IDLE, MCTEC_ST_ARM, MCTEC_ST_RUN} mctec_state_t;
endpackage

/* verilog/mctec_event_filter.sv */
// event pin synchroniser, two-sample noise filter and edge detector
`timescale 1ns/10ps
module mctec_event_filter
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic pin_i,
    input wire logic [1:0] edge_sel_i,
    output logic edge_o
);
    import mctec_pkg::*;
    logic sync1_reg;
    logic sync2_reg;
    logic samp_reg;
    logic level_reg;
    logic edge_next;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
        end
    end

    // accept a new level only after two equal samples
    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            samp_reg <= 1'b0;
            level_reg <= 1'b0;
        end
        else
        begin
            samp_reg <= sync2_reg;
            if (samp_reg == sync2_reg)
            begin
                level_reg <= sync2_reg;
            end
        end
    end

    always_comb
    begin
        edge_next = 1'b0;
        if (samp_reg == sync2_reg && level_reg != sync2_reg)
        begin
            if (edge_sel_i == MCTEC_EDGE_BOTH)
            begin
                edge_next = 1'b1;
            end
            else if (edge_sel_i == MCTEC_EDGE_RISE)
            begin
                edge_next = sync2_reg;
            end
            else if (edge_sel_i == MCTEC_EDGE_FALL)
            begin
                edge_next = ~sync2_reg;
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            edge_o <= 1'b0;
        end
        else
        begin
            edge_o <= edge_next;
        end
    end

    AST_FILTER_GLITCH: assert property (@(posedge mclk_i) disable iff (reset_i)
        edge_o |-> $past(samp_reg) == $past(sync2_reg))
        else $error("edge accepted without two equal samples");
endmodule

/* verif/mctec_event_src.sv */
// event pin source model: clean pulse trains and single-sample glitches
`timescale 1ns/10ps
module mctec_event_src
(
    input wire logic mclk_i,
    input wire logic load_i,
    input wire logic [3:0] num_i,
    input wire logic glitch_i,
    output logic pin_o,
    output logic busy_o
);
    logic [3:0] left_reg;
    logic [2:0] phase_reg;
    initial left_reg = 4'h0;
    initial phase_reg = 3'h0;
    ////////////////////////////////////////////////////////////////
    // three cycles high, three low: stays above the two-cycle minimum
    always @(posedge mclk_i)
    begin
        if (load_i)
        begin
            left_reg <= num_i;
            phase_reg <= 3'h0;
        end
        else if (left_reg != 4'h0)
        begin
            phase_reg <= (phase_reg == 3'h5) ? 3'h0 : phase_reg + 3'h1;
            if (phase_reg == 3'h5)
                left_reg <= left_reg - 4'h1;
        end
    end
    // glitch is a deliberate one-cycle breach, only when a scenario asks
    assign pin_o = ((left_reg != 4'h0) && (phase_reg < 3'h3)) || glitch_i;
    assign busy_o = (left_reg != 4'h0);
endmodule

/* verif/mctec_timer_tb_top.sv */
// testbench for the match-clear timer/event counter
`timescale 1ns/10ps
module mctec_timer_tb_top;
    import mctec_pkg::*;
    typedef struct {logic [1:0] s; logic [15:0] m; int dlo; int dhi;} mctec_row_t;
    mctec_row_t rows [3] = '{'{2'h0, 16'h0003, MCTEC_DIV_A, MCTEC_DIV_A},
        '{2'h1, 16'h0002, MCTEC_DIV_B_LOW, MCTEC_DIV_B_HIGH}, '{2'h2, 16'h0001, MCTEC_DIV_C_LOW, MCTEC_DIV_C_HIGH}};
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] run = 2'h0;
    logic [1:0] src = 2'h0;
    logic [15:0] cmp0 = 16'h0003;
    logic oe = 1'b1;
    logic [1:0] edge_sel = MCTEC_EDGE_RISE;
    logic [15:0] cmp1 = 16'h0001;
    logic tog0 = 1'b1;
    logic tog1 = 1'b0;
    logic load = 1'b0;
    logic glitch = 1'b0;
    logic [3:0] num = 4'h0;
    logic ev, busy, mz_lo, mo_lo, ov_lo, pin_lo, mz_hi, ov_hi, pin_hi;
    logic [15:0] cnt_lo, cnt_hi;
    logic [31:0] cyc = 0, t_lo = 0, t_hi = 0, t_mo = 0, tp_lo = 0, tp_hi = 0, irq_n = 0;
    logic [31:0] p_lo = 0, p_hi = 0, p_mo = 0, pp_lo = 0, pp_hi = 0, exp_lo, exp_hi, irq0;
    logic pin_lo_d = 1'b0, pin_hi_d = 1'b0;
    int num_errors = 0;
    int checks = 0;
    always #12.5 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////
    mctec_timer #(.INSTANCE(0)) uut (.mclk_i(mclk_i), .reset_i(reset_i), .run_mode_i(run), .source_select_i(src),
        .event_edge_sel_i(edge_sel), .compare_zero_i(cmp0), .compare_one_i(cmp1),
        .toggle_on_match_zero_i(tog0), .toggle_on_match_one_i(tog1), .output_enable_bit_i(oe),
        .overflow_clear_i(1'b0), .event_input_pin_i(ev), .counter_value_o(cnt_lo), .match_zero_irq_o(mz_lo),
        .match_one_irq_o(mo_lo), .overflow_flag_o(ov_lo), .timer_output_pin_o(pin_lo));
    mctec_timer #(.INSTANCE(2)) uut_hi (.mclk_i(mclk_i), .reset_i(reset_i), .run_mode_i(run), .source_select_i(src),
        .event_edge_sel_i(edge_sel), .compare_zero_i(cmp0), .compare_one_i(cmp1),
        .toggle_on_match_zero_i(tog0), .toggle_on_match_one_i(tog1), .output_enable_bit_i(oe),
        .overflow_clear_i(1'b0), .event_input_pin_i(ev), .counter_value_o(cnt_hi), .match_zero_irq_o(mz_hi),
        .match_one_irq_o(), .overflow_flag_o(ov_hi), .timer_output_pin_o(pin_hi));
    mctec_event_src partner (.mclk_i(mclk_i), .load_i(load), .num_i(num), .glitch_i(glitch), .pin_o(ev),
        .busy_o(busy));
    ////////////////////////////////////////////////////////////////
    // spacing of events and toggles, measured in clock cycles
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        pin_lo_d <= pin_lo;
        pin_hi_d <= pin_hi;
        if (mz_lo === 1'b1)
        begin
            p_lo <= cyc - t_lo;
            t_lo <= cyc;
            irq_n <= irq_n + 1;
        end
        if (mz_hi === 1'b1)
        begin
            p_hi <= cyc - t_hi;
            t_hi <= cyc;
        end
        if (mo_lo === 1'b1)
        begin
            p_mo <= cyc - t_mo;
            t_mo <= cyc;
        end
        if (pin_lo !== pin_lo_d)
        begin
            pp_lo <= cyc - tp_lo;
            tp_lo <= cyc;
        end
        if (pin_hi !== pin_hi_d)
        begin
            pp_hi <= cyc - tp_hi;
            tp_hi <= cyc;
        end
    end
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic send(input logic [3:0] n);
        @(negedge mclk_i);
        load = 1'b1;
        num = n;
        @(negedge mclk_i);
        load = 1'b0;
        for (int k = 0; k < 100 && busy === 1'b1; k++)
            @(negedge mclk_i);
        repeat (8) @(negedge mclk_i);
    endtask
    always @(negedge mclk_i)
    begin
        if (mz_lo === 1'b1)
            check("counter_at_match", 32'h0, {16'h0, cnt_lo});
        if (mz_hi === 1'b1)
            check("counter_at_match_hi", 32'h0, {16'h0, cnt_hi});
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge mclk_i);
        reset_i = 1'b0;
        check("reset_out", 32'h0, {cnt_lo, 12'h0, mz_lo, mo_lo, ov_lo, pin_lo});
        foreach (rows[i])
        begin
            src = rows[i].s;
            cmp0 = rows[i].m;
            run = MCTEC_RUN_MATCH;
            exp_lo = (rows[i].m + 1) * rows[i].dlo;
            exp_hi = (rows[i].m + 1) * rows[i].dhi;
            repeat (3 * (rows[i].m + 2) * rows[i].dhi + 40) @(negedge mclk_i);
            check("period_lo", exp_lo, p_lo);
            check("period_hi", exp_hi, p_hi);
            check("half_wave_lo", exp_lo, pp_lo);
            check("half_wave_hi", exp_hi, pp_hi);
            check("match_one_period", exp_lo, p_mo);
            check("overflow", 32'h0, {ov_lo, ov_hi});
            run = MCTEC_RUN_STOP;
            repeat (3) @(negedge mclk_i);
            check("stopped", 32'h0, {cnt_lo, cnt_hi});
            check("stopped_pin", 32'h0, {30'h0, pin_lo, pin_hi});
        end
        // pin held low while output is disabled, counting continues
        oe = 1'b0;
        src = 2'h0;
        cmp0 = 16'h0001;
        run = MCTEC_RUN_MATCH;
        for (int k = 0; k < 20; k++)
        begin
            repeat (3) @(negedge mclk_i);
            check("pin_disabled", 32'h0, {31'h0, pin_lo});
        end
        run = MCTEC_RUN_STOP;
        repeat (3) @(negedge mclk_i);
        // event counting: first edge starts, glitch must be ignored
        oe = 1'b1;
        src = MCTEC_SRC_EVENT;
        cmp0 = 16'h0002;
        run = MCTEC_RUN_MATCH;
        repeat (2) @(negedge mclk_i);
        irq0 = irq_n;
        send(4'h2);
        check("event_count", 32'h1, {16'h0, cnt_lo});
        glitch = 1'b1;
        @(negedge mclk_i);
        glitch = 1'b0;
        repeat (8) @(negedge mclk_i);
        check("glitch_count", 32'h1, {16'h0, cnt_lo});
        send(4'h1);
        check("no_early_irq", irq0, irq_n);
        send(4'h1);
        check("first_irq", irq0 + 1, irq_n);
        send(4'h3);
        check("next_irq", irq0 + 2, irq_n);
        // both edges: one pulse gives two events, the first still swallowed
        run = MCTEC_RUN_STOP;
        edge_sel = MCTEC_EDGE_BOTH;
        repeat (3) @(negedge mclk_i);
        irq0 = irq_n;
        run = MCTEC_RUN_MATCH;
        repeat (2) @(negedge mclk_i);
        send(4'h2);
        check("both_edges_irq", irq0 + 1, irq_n);
        check("both_edges_count", 32'h0, {16'h0, cnt_lo});
        run = MCTEC_RUN_STOP;
        edge_sel = MCTEC_EDGE_FALL;
        repeat (3) @(negedge mclk_i);
        run = MCTEC_RUN_MATCH;
        repeat (2) @(negedge mclk_i);
        send(4'h2);
        check("fall_edges_count", 32'h1, {16'h0, cnt_lo});
        // pin inverts on compare one only, so half wave is a full period
        run = MCTEC_RUN_STOP;
        edge_sel = MCTEC_EDGE_RISE;
        repeat (3) @(negedge mclk_i);
        src = 2'h0;
        cmp0 = 16'h0003;
        tog0 = 1'b0;
        tog1 = 1'b1;
        run = MCTEC_RUN_MATCH;
        repeat (100) @(negedge mclk_i);
        check("half_wave_one", 4 * MCTEC_DIV_A, pp_lo);
        check("half_wave_one_hi", 4 * MCTEC_DIV_A, pp_hi);
        // reset in mid-run clears every output, counting restarts cleanly
        reset_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        check("reset_mid", 32'h0, {cnt_lo, 12'h0, mz_lo, mo_lo, ov_lo, pin_lo});
        reset_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        check("after_reset", 32'h0, {cnt_hi, 13'h0, mz_hi, ov_hi, pin_hi});
        print_verdict();
    end
    initial
    begin
        #(70000 * 25);
        num_errors++;
        print_verdict();
    end
endmodule
